// file: core/uart_modem_status_irq.sv
// Modem status, interrupt enable and interrupt identification for one UART channel
`timescale 1ns/1ps
`default_nettype none
module uart_modem_status_irq
  import modem_irq_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Modem pins, active low
  input  wire logic        cdN,
  input  wire logic        riN,
  input  wire logic        dsrN,
  input  wire logic        ctsN,
  // Event levels from the rest of the channel, same clock
  input  wire logic        lineErr,
  input  wire logic        rxTimeout,
  input  wire logic        rxReady,
  input  wire logic        txBelowThr,
  input  wire logic        xoffDetect,
  input  wire logic        rtsRise,
  input  wire logic        ctsRise,
  // Interrupt pin and its drive enable, plus loop-back and sleep enables
  output logic             irqOut,
  output logic             irqOe,
  output logic             loopbackEn,
  output logic             sleepEn
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  ier_reg, ier_next;
  logic [7:0]  mcr_reg, mcr_next;
  logic [7:0]  efr_reg, efr_next;
  logic [7:0]  fcr_reg, fcr_next;
  logic [3:0]  delta_reg, delta_next;
  logic [3:0]  lvlPrev_reg, lvlPrev_next;
  logic        thrArm_reg, thrArm_next;
  logic        xoffFlag_reg, xoffFlag_next;
  logic        flowFlag_reg, flowFlag_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  logic        irqOut_reg, irqOut_next;
  logic        irqOe_reg, irqOe_next;
  logic        u_txPrev_reg, u_txPrev_next;

  logic [3:0]  pinSync;
  logic [3:0]  pinLevel;
  logic [3:0]  curLevel;
  logic [7:0]  msrValue;
  logic [7:0]  iirValue;
  logic [5:0]  idCode;
  src_t        source;
  logic        pending;
  logic        setup, wrIer, rdMsr, rdIir;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  modem_sync #(.WIDTH(4)) u_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .asyncIn ({cdN, riN, dsrN, ctsN}),
    .syncOut (pinSync)
  );

  function automatic logic isAddr(input logic [7:0] a, input logic [7:0] ref_a);
    return a == ref_a;
  endfunction : isAddr

  // Level order CD, RI, DSR, CTS matches status bits 7..4
  assign pinLevel = ~pinSync;
  always_comb
  begin
    if (mcr_reg[MCR_LOOP_BIT])
      curLevel = {mcr_reg[3], mcr_reg[2], mcr_reg[0], mcr_reg[1]};
    else
      curLevel = pinLevel;
  end
  assign msrValue = {curLevel, delta_reg};

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Decode in the first access cycle; the effect and pready both land at the edge that ends it
  assign setup = psel && penable && !pready_reg;
  assign wrIer = setup && pwrite && isAddr(paddr, ADDR_INT_ENABLE);
  assign rdMsr = setup && !pwrite && isAddr(paddr, ADDR_MODEM_STATUS);
  assign rdIir = setup && !pwrite && isAddr(paddr, ADDR_INT_IDENT);

  // ----------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------
  irq_prio_encode u_prio (
    .lineReq    (ier_reg[IER_LINE_BIT] && lineErr),
    .timeoutReq (ier_reg[IER_RHR_BIT] && rxTimeout),
    .rhrReq     (ier_reg[IER_RHR_BIT] && rxReady),
    .thrReq     (ier_reg[IER_THR_BIT] && thrArm_reg),
    .modemReq   (ier_reg[IER_MODEM_BIT] && (delta_reg != 4'h0)),
    .xoffReq    (ier_reg[IER_XOFF_BIT] && xoffFlag_reg),
    .flowReq    ((ier_reg[IER_CTS_BIT] || ier_reg[IER_RTS_BIT]) && flowFlag_reg),
    .idCode     (idCode),
    .source     (source)
  );
  assign pending  = (source != SRC_NONE);
  assign iirValue = {fcr_reg[FCR_FIFOEN_BIT], fcr_reg[FCR_FIFOEN_BIT], idCode};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    ier_next      = ier_reg;
    mcr_next      = mcr_reg;
    efr_next      = efr_reg;
    fcr_next      = fcr_reg;
    delta_next    = delta_reg;
    lvlPrev_next  = curLevel;
    thrArm_next   = thrArm_reg;
    xoffFlag_next = xoffFlag_reg;
    flowFlag_next = flowFlag_reg;
    prdata_next   = 32'h0000_0000;
    pready_next   = setup;
    pslverr_next  = 1'b0;

    if (setup && pwrite)
    begin
      unique case (paddr)
        ADDR_INT_ENABLE:
        begin
          ier_next[3:0] = pwdata[3:0];
          if (efr_reg[EFR_ENH_BIT])
            ier_next[7:4] = pwdata[7:4];
        end
        ADDR_MODEM_CONTROL:
        begin
          mcr_next[4:0] = pwdata[4:0];
          if (efr_reg[EFR_ENH_BIT])
            mcr_next[7:5] = pwdata[7:5];
        end
        ADDR_ENH_FEATURE:  efr_next = pwdata[7:0];
        ADDR_FIFO_CONTROL: fcr_next = pwdata[7:0];
        ADDR_MODEM_STATUS, ADDR_INT_IDENT, ADDR_SOURCES: ;
        default:           pslverr_next = 1'b1;
      endcase
    end
    else if (setup)
    begin
      unique case (paddr)
        ADDR_MODEM_STATUS:  prdata_next = {24'h000000, msrValue};
        ADDR_INT_ENABLE:    prdata_next = {24'h000000, ier_reg};
        ADDR_INT_IDENT:     prdata_next = {24'h000000, iirValue};
        ADDR_MODEM_CONTROL: prdata_next = {24'h000000, mcr_reg};
        ADDR_ENH_FEATURE:   prdata_next = {24'h000000, efr_reg};
        ADDR_FIFO_CONTROL:  prdata_next = {24'h000000, fcr_reg};
        ADDR_SOURCES:       prdata_next = {29'h0, xoffFlag_reg, flowFlag_reg, thrArm_reg};
        default:            pslverr_next = 1'b1;
      endcase
    end

    // Clear on read first, so a change in the same cycle still sets
    if (rdMsr)
      delta_next = 4'h0;
    if (curLevel[3] != lvlPrev_reg[3])
      delta_next[3] = 1'b1;
    if (curLevel[2] && !lvlPrev_reg[2])
      delta_next[2] = 1'b1;
    if (curLevel[1] != lvlPrev_reg[1])
      delta_next[1] = 1'b1;
    if (curLevel[0] != lvlPrev_reg[0])
      delta_next[0] = 1'b1;

    // Transmit interrupt arms on entering below-threshold, not on re-enable
    if (!txBelowThr || (rdIir && source == SRC_THR))
      thrArm_next = 1'b0;
    if (txBelowThr && !thrArm_reg && !u_txPrev_reg)
      thrArm_next = 1'b1;

    if (rdIir && source == SRC_XOFF)
      xoffFlag_next = 1'b0;
    if (xoffDetect)
      xoffFlag_next = 1'b1;
    if (rdIir && source == SRC_FLOW)
      flowFlag_next = 1'b0;
    if ((rtsRise && ier_reg[IER_RTS_BIT]) || (ctsRise && ier_reg[IER_CTS_BIT]))
      flowFlag_next = 1'b1;

    if (!nrst)
    begin
      ier_next      = IER_RESET;
      mcr_next      = MCR_RESET;
      efr_next      = EFR_RESET;
      fcr_next      = FCR_RESET;
      delta_next    = 4'h0;
      lvlPrev_next  = 4'h0;
      thrArm_next   = 1'b0;
      xoffFlag_next = 1'b0;
      flowFlag_next = 1'b0;
      prdata_next   = 32'h0000_0000;
      pready_next   = 1'b0;
      pslverr_next  = 1'b0;
    end
  end

  // Previous below-threshold level; reset high so an empty FIFO after reset is no edge
  assign u_txPrev_next = nrst ? txBelowThr : 1'b1;

  // Interrupt pin: high while pending, floats when disabled
  always_comb
  begin
    irqOut_next = pending;
    irqOe_next  = mcr_reg[MCR_IRQEN_BIT];
    if (!nrst)
    begin
      irqOut_next = 1'b0;
      irqOe_next  = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    ier_reg      <= ier_next;
    mcr_reg      <= mcr_next;
    efr_reg      <= efr_next;
    fcr_reg      <= fcr_next;
    delta_reg    <= delta_next;
    lvlPrev_reg  <= lvlPrev_next;
    thrArm_reg   <= thrArm_next;
    xoffFlag_reg <= xoffFlag_next;
    flowFlag_reg <= flowFlag_next;
    prdata_reg   <= prdata_next;
    pready_reg   <= pready_next;
    pslverr_reg  <= pslverr_next;
    irqOut_reg   <= irqOut_next;
    irqOe_reg    <= irqOe_next;
    u_txPrev_reg <= u_txPrev_next;
  end

  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign irqOut     = irqOut_reg;
  assign irqOe      = irqOe_reg;
  assign loopbackEn = mcr_reg[MCR_LOOP_BIT];
  assign sleepEn    = ier_reg[IER_SLEEP_BIT];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ier_high_lock: assert property (@(posedge sys_clk) disable iff (!nrst)
    (wrIer && !efr_reg[EFR_ENH_BIT]) |=> ier_reg[7:4] == $past(ier_reg[7:4]))
    else $error("interrupt enable upper bits changed while locked");
  a_ier_low_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    wrIer |=> ier_reg[3:0] == $past(pwdata[3:0]))
    else $error("interrupt enable low bits not written");
  a_irq_follows: assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(nrst) |-> irqOut == $past(pending))
    else $error("interrupt output does not follow pending");
  a_irq_drops: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!pending ##1 !pending) |=> !irqOut)
    else $error("interrupt output stayed high with nothing pending");
  a_ident_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
    iirValue[0] == !pending)
    else $error("ident bit 0 does not match pending");
  a_ident_mirror: assert property (@(posedge sys_clk) disable iff (!nrst)
    iirValue[7] == fcr_reg[0] && iirValue[6] == fcr_reg[0])
    else $error("ident bits 7 and 6 do not mirror fifo enable");
  a_line_top: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ier_reg[IER_LINE_BIT] && lineErr) |-> idCode == ID_LINE)
    else $error("line status not reported first");
  a_loop_map: assert property (@(posedge sys_clk) disable iff (!nrst)
    mcr_reg[MCR_LOOP_BIT] |-> msrValue[7:4] == {mcr_reg[3], mcr_reg[2], mcr_reg[0], mcr_reg[1]})
    else $error("loop-back status mapping wrong");
  a_ri_rise_only: assert property (@(posedge sys_clk) disable iff (!nrst)
    ($fell(curLevel[2]) && !delta_reg[2]) |=> !delta_reg[2])
    else $error("ring flag set on falling edge");
  a_cd_change: assert property (@(posedge sys_clk) disable iff (!nrst)
    (curLevel[3] != lvlPrev_reg[3]) |=> delta_reg[3])
    else $error("carrier change flag not set");
  a_irq_enable: assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(nrst) |-> irqOe == $past(mcr_reg[MCR_IRQEN_BIT]))
    else $error("interrupt output enable wrong");

  c_msr_read: cover property (@(posedge sys_clk) disable iff (!nrst) rdMsr && delta_reg != 4'h0);
  c_loopback: cover property (@(posedge sys_clk) disable iff (!nrst) mcr_reg[MCR_LOOP_BIT] && delta_reg[3]);
  c_thr_irq:  cover property (@(posedge sys_clk) disable iff (!nrst) source == SRC_THR ##1 irqOut);
  c_flow_irq: cover property (@(posedge sys_clk) disable iff (!nrst) source == SRC_FLOW);
endmodule : uart_modem_status_irq
`default_nettype wire

// file: common/modem_irq_pkg.sv
// Package: register offsets, field positions, reset values and encodings for the modem status and interrupt block
//
// Notes on behaviour
// - Normal mode: status bits 7..4 are inverted CD, RI, DSR, CTS pins.
// - Loop-back: status 7,6,5,4 follow modem control bits 3,2,0,1.
// - CD, DSR, CTS change flags set on any change; cleared by status read.
// - RI change flag sets only on RI rising; cleared by status read.
// - Enable bits 7..4: CTS, RTS, Xoff interrupts and sleep; reset 0.
// - Enable bits 3..0: modem, line status, transmit, receive; reset 0.
// - Enable bits 7..4 are written only while enhanced bit 4 is set.
// - Re-enabling transmit interrupt gives no new one below threshold.
// - Interrupt output asserts while any enabled source is pending.
// - Ident bit 0 is 0 when pending, 1 when idle; read-only.
// - Ident bits 7 and 6 mirror FIFO enable bit.
// - Ident bit 5 flags RTS/CTS rise; bit 4 flags Xoff/special char.
// - Highest pending source reported; line status is top, code 011.
// - Time-out and receive share level 2; time-out also sets bit 3.
// - Transmit is level 3, bit 1 alone; modem is level 4, all zero.
// - Xoff level 5 shows bit 4; RTS/CTS rise level 6 shows bit 5.
// - Modem control bit 4 selects loop-back for the status inputs.
// - Modem control bit 3 low floats interrupt output; high drives it.
package modem_irq_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODEM_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_INT_ENABLE    = 8'h04;
  localparam logic [7:0] ADDR_INT_IDENT     = 8'h08;
  localparam logic [7:0] ADDR_MODEM_CONTROL = 8'h0c;
  localparam logic [7:0] ADDR_ENH_FEATURE   = 8'h10;
  localparam logic [7:0] ADDR_FIFO_CONTROL  = 8'h14;
  localparam logic [7:0] ADDR_SOURCES       = 8'h18;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int MCR_LOOP_BIT   = 4;
  localparam int MCR_IRQEN_BIT  = 3;
  localparam int EFR_ENH_BIT    = 4;
  localparam int FCR_FIFOEN_BIT = 0;
  localparam int IER_CTS_BIT    = 7;
  localparam int IER_RTS_BIT    = 6;
  localparam int IER_XOFF_BIT   = 5;
  localparam int IER_SLEEP_BIT  = 4;
  localparam int IER_MODEM_BIT  = 3;
  localparam int IER_LINE_BIT   = 2;
  localparam int IER_THR_BIT    = 1;
  localparam int IER_RHR_BIT    = 0;
  localparam logic [7:0] IER_RESET  = 8'h00;
  localparam logic [7:0] MCR_RESET  = 8'h00;
  localparam logic [7:0] EFR_RESET  = 8'h00;
  localparam logic [7:0] FCR_RESET  = 8'h00;
  localparam logic [3:0] IER_HI_MASK = 4'hf;

  // ----------------------------------------------------------------
  // Identification codes, bits 5..0
  // ----------------------------------------------------------------
  localparam logic [5:0] ID_NONE    = 6'h01;
  localparam logic [5:0] ID_LINE    = 6'h06;
  localparam logic [5:0] ID_TIMEOUT = 6'h0c;
  localparam logic [5:0] ID_RHR     = 6'h04;
  localparam logic [5:0] ID_THR     = 6'h02;
  localparam logic [5:0] ID_MODEM   = 6'h00;
  localparam logic [5:0] ID_XOFF    = 6'h10;
  localparam logic [5:0] ID_FLOW    = 6'h20;

  typedef enum logic [2:0] {SRC_NONE, SRC_LINE, SRC_TIMEOUT, SRC_RHR, SRC_THR, SRC_MODEM, SRC_XOFF, SRC_FLOW} src_t;
endpackage : modem_irq_pkg

// file: core/modem_sync.sv
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module modem_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage1_next;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage2_next;

  initial
  begin
    if (WIDTH < 1) $error("modem_sync: WIDTH must be at least 1");
  end

  // Idle level of active-low pins is high, so reset to ones avoids a false change
  always_comb
  begin
    stage1_next = asyncIn;
    stage2_next = stage1_reg;
    if (!nrst)
    begin
      stage1_next = '1;
      stage2_next = '1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    stage1_reg <= stage1_next;
    stage2_reg <= stage2_next;
  end

  assign syncOut = stage2_reg;
endmodule : modem_sync
`default_nettype wire

// file: core/irq_prio_encode.sv
// Priority encoder from pending sources to identification code
`timescale 1ns/1ps
`default_nettype none
module irq_prio_encode
  import modem_irq_pkg::*;
(
  input  wire logic       lineReq,
  input  wire logic       timeoutReq,
  input  wire logic       rhrReq,
  input  wire logic       thrReq,
  input  wire logic       modemReq,
  input  wire logic       xoffReq,
  input  wire logic       flowReq,
  output logic      [5:0] idCode,
  output var src_t        source
);
  always_comb
  begin
    source = SRC_NONE;
    idCode = ID_NONE;
    if (lineReq)
    begin
      source = SRC_LINE;
      idCode = ID_LINE;
    end
    else if (timeoutReq)
    begin
      source = SRC_TIMEOUT;
      idCode = ID_TIMEOUT;
    end
    else if (rhrReq)
    begin
      source = SRC_RHR;
      idCode = ID_RHR;
    end
    else if (thrReq)
    begin
      source = SRC_THR;
      idCode = ID_THR;
    end
    else if (modemReq)
    begin
      source = SRC_MODEM;
      idCode = ID_MODEM;
    end
    else if (xoffReq)
    begin
      source = SRC_XOFF;
      idCode = ID_XOFF;
    end
    else if (flowReq)
    begin
      source = SRC_FLOW;
      idCode = ID_FLOW;
    end
  end
endmodule : irq_prio_encode
`default_nettype wire

// file: dv/apb_host_model.sv
// APB host model that issues single register transfers to the block
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
  input  wire logic        sys_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // ----------------------------------------------------------------
  // One transfer, held until pready is seen at a rising edge or 20 edges pass without it
  // ----------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err, output logic hung);
    int i;
    hung  = 1'b1;
    err   = 1'b0;
    rdata = 32'h0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 20 && hung; i++)
    begin
      @(posedge sys_clk);
      if (pready === 1'b1)
      begin
        rdata = prdata;
        err   = pslverr;
        hung  = 1'b0;
      end
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines show garbage so a stale value is never trusted
    paddr   <= ~addr;
    pwdata  <= ~wdata;
  endtask : xfer
endmodule : apb_host_model
`default_nettype wire

// file: dv/uart_modem_status_irq_tb.sv
// Self-checking testbench for the modem status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module uart_modem_status_irq_tb;
  import modem_irq_pkg::*;
  logic        sys_clk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  pinN;
  logic        lineErr;
  logic        rxTimeout;
  logic        rxReady;
  logic        txBelowThr;
  logic        xoffDetect;
  logic        rtsRise;
  logic        ctsRise;
  logic        irqOut;
  logic        irqOe;
  logic        loopbackEn;
  logic        sleepEn;
  int          errCount;
  int          nTests;

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  apb_host_model i_host (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Pin vector index k matches change flag bit k and status bit k+4
  uart_modem_status_irq i_dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cdN(pinN[3]), .riN(pinN[2]), .dsrN(pinN[1]), .ctsN(pinN[0]), .lineErr(lineErr), .rxTimeout(rxTimeout),
    .rxReady(rxReady), .txBelowThr(txBelowThr), .xoffDetect(xoffDetect), .rtsRise(rtsRise),
    .ctsRise(ctsRise), .irqOut(irqOut), .irqOe(irqOe), .loopbackEn(loopbackEn), .sleepEn(sleepEn));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic conclude;
    if (errCount == 0 && nTests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    nTests++;
    if (got !== exp)
    begin
      errCount++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] d, output logic r);
    logic hung;
    i_host.xfer(w, a, wd, d, r, hung);
    if (hung)
    begin
      errCount++;
      $display("[ERR] %0t bus transfer never answered", $time);
      conclude();
    end
  endtask : acc

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic        r;
    acc(1'b1, a, wd, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff,
                    input logic ee = 1'b0);
    logic [31:0] d;
    logic        r;
    acc(1'b0, a, 32'h0, d, r);
    chk(32'(r), 32'(ee), "slave error");
    if (ee == 1'b0)
      chk(d & m, e & m, "read data");
  endtask : rd

  // Bounded wait for the interrupt line to reach a level
  task automatic waitIrq(input logic e);
    int i;
    for (i = 0; i < 10 && irqOut !== e; i++)
      @(posedge sys_clk);
    chk(32'(irqOut), 32'(e), "interrupt line");
    if (irqOut !== e)
      conclude();
  endtask : waitIrq

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    nrst = 1'b0;
    pinN = 4'hf;
    {lineErr, rxTimeout, rxReady, txBelowThr, xoffDetect, rtsRise, ctsRise} = 7'h00;
    errCount = 0;
    nTests = 0;
    cyc(10);
    nrst <= 1'b1;
    rd(ADDR_INT_ENABLE, 32'h00);
    rd(ADDR_INT_IDENT, 32'h01);
    wr(ADDR_INT_IDENT, 32'hff);
    rd(ADDR_INT_IDENT, 32'h01);
    rd(8'h1c, 32'h0, 32'h0, 1'b1);
    chk(32'(irqOut), 32'h0, "idle interrupt");
    for (int k = 0; k < 4; k++)
    begin
      pinN[k] <= 1'b0;
      cyc(5);
      rd(ADDR_MODEM_STATUS, (32'h10 << k) | (32'h1 << k), (k == 2) ? 32'hfb : 32'hff);
      rd(ADDR_MODEM_STATUS, 32'h10 << k);
      pinN[k] <= 1'b1;
      cyc(5);
      rd(ADDR_MODEM_STATUS, 32'h1 << k, (k == 2) ? 32'hfb : 32'hff);
    end
    rd(ADDR_MODEM_STATUS, 32'h00);
    wr(ADDR_MODEM_CONTROL, 32'h10);
    cyc(3);
    chk(32'(loopbackEn), 32'h1, "loop-back enable");
    rd(ADDR_MODEM_STATUS, 32'h00);
    wr(ADDR_MODEM_CONTROL, 32'h19);
    cyc(3);
    rd(ADDR_MODEM_STATUS, 32'haa);
    wr(ADDR_MODEM_CONTROL, 32'h1e);
    cyc(3);
    rd(ADDR_MODEM_STATUS, 32'hd7);
    wr(ADDR_MODEM_CONTROL, 32'h1a);
    cyc(3);
    rd(ADDR_MODEM_STATUS, 32'h90);
    wr(ADDR_MODEM_CONTROL, 32'h00);
    cyc(5);
    rd(ADDR_MODEM_STATUS, 32'h00, 32'hf0);
    rd(ADDR_MODEM_STATUS, 32'h00);
    wr(ADDR_INT_ENABLE, 32'hff);
    rd(ADDR_INT_ENABLE, 32'h0f);
    chk(32'(sleepEn), 32'h0, "sleep enable");
    wr(ADDR_MODEM_CONTROL, 32'h08);
    cyc(2);
    chk(32'(irqOe), 32'h1, "interrupt drive");
    // Line, time-out, receive, transmit and modem sources pending at once, peeled off from the top
    {lineErr, rxTimeout, rxReady, txBelowThr} <= 4'hf;
    pinN[0] <= 1'b0;
    cyc(5);
    waitIrq(1'b1);
    rd(ADDR_INT_IDENT, 32'h06);
    lineErr <= 1'b0;
    rd(ADDR_INT_IDENT, 32'h0c);
    rxTimeout <= 1'b0;
    rd(ADDR_INT_IDENT, 32'h04);
    rxReady <= 1'b0;
    rd(ADDR_INT_IDENT, 32'h02);
    rd(ADDR_INT_IDENT, 32'h00);
    wr(ADDR_INT_ENABLE, 32'h0d);
    wr(ADDR_INT_ENABLE, 32'h0f);
    rd(ADDR_INT_IDENT, 32'h00);
    rd(ADDR_MODEM_STATUS, 32'h11);
    waitIrq(1'b0);
    rd(ADDR_INT_IDENT, 32'h01);
    wr(ADDR_ENH_FEATURE, 32'h10);
    wr(ADDR_INT_ENABLE, 32'hff);
    rd(ADDR_INT_ENABLE, 32'hff);
    chk(32'(sleepEn), 32'h1, "sleep enable");
    wr(ADDR_INT_ENABLE, 32'hef);
    @(posedge sys_clk);
    xoffDetect <= 1'b1;
    ctsRise <= 1'b1;
    @(posedge sys_clk);
    xoffDetect <= 1'b0;
    ctsRise <= 1'b0;
    waitIrq(1'b1);
    rd(ADDR_SOURCES, 32'h06);
    rd(ADDR_INT_IDENT, 32'h10);
    rd(ADDR_INT_IDENT, 32'h20);
    rd(ADDR_INT_IDENT, 32'h01);
    waitIrq(1'b0);
    wr(ADDR_FIFO_CONTROL, 32'h01);
    @(posedge sys_clk);
    rtsRise <= 1'b1;
    @(posedge sys_clk);
    rtsRise <= 1'b0;
    rd(ADDR_INT_IDENT, 32'he0);
    rd(ADDR_INT_IDENT, 32'hc1);
    wr(ADDR_MODEM_CONTROL, 32'h00);
    cyc(2);
    chk(32'(irqOe), 32'h0, "interrupt drive");
    conclude();
  end
endmodule : uart_modem_status_irq_tb
`default_nettype wire
